// ==== logic/ycd_pkg.sv ====
// Constants, types and helpers shared by the Y/C display data path.
// Assumes a 32-bit APB slave on pclk at 100 MHz.
package ycd_pkg;

  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_PORT  = 8'h04;
  localparam logic [7:0] ADDR_THR   = 8'h08;
  localparam logic [7:0] ADDR_CNT   = 8'h0C;
  localparam logic [7:0] ADDR_HBL   = 8'h10;
  localparam logic [7:0] ADDR_WIN   = 8'h14;
  localparam logic [7:0] ADDR_LINE  = 8'h18;
  localparam logic [7:0] ADDR_DEF   = 8'h1C;
  localparam logic [7:0] ADDR_STAT  = 8'h20;
  localparam logic [7:0] ADDR_Y_LO  = 8'h40;
  localparam logic [7:0] ADDR_Y_HI  = 8'h44;
  localparam logic [7:0] ADDR_CB_LO = 8'h48;
  localparam logic [7:0] ADDR_CB_HI = 8'h4C;
  localparam logic [7:0] ADDR_CR_LO = 8'h50;
  localparam logic [7:0] ADDR_CR_HI = 8'h54;

  localparam int CTRL_EN     = 0;
  localparam int CTRL_FMT    = 1;
  localparam int CTRL_YC     = 4;
  localparam int CTRL_SCALE  = 5;
  localparam int CTRL_CHROMA_RESAMPLE_ENABLE = 6;
  localparam int CTRL_DVE    = 7;
  localparam int CTRL_VBI    = 8;
  localparam int CTRL_VFLAG  = 9;
  localparam int CTRL_FFLAG  = 10;
  localparam int CTRL_PROG   = 11;
  localparam int HI_LSB      = 16;

  localparam int LUMA_BYTES   = 2560;
  localparam int CHROMA_BYTES = 1280;
  localparam int LUMA_WORDS   = LUMA_BYTES / 8;
  localparam int CHROMA_WORDS = CHROMA_BYTES / 8;

  localparam logic [7:0] BLANK_Y  = 8'h10;
  localparam logic [7:0] BLANK_C  = 8'h80;
  localparam logic [7:0] CODE_PRE = 8'hFF;

  localparam logic [11:0] RST_LINE_LAST = 12'h359;
  localparam logic [11:0] RST_HBEGIN    = 12'h2D0;
  localparam logic [11:0] RST_HEND      = 12'h354;
  localparam logic [11:0] RST_WIN_START = 12'h000;
  localparam logic [11:0] RST_WIN_STOP  = 12'h2D0;
  localparam logic [12:0] RST_THR       = 13'h0100;

  typedef enum logic [1:0] {SECT_ACT, SECT_EAV, SECT_HBL, SECT_SAV} ycd_sect_t;
  typedef enum logic [1:0] {FILT_NONE, FILT_SCALE, FILT_CHROMA_RESAMPLE_ENABLE, FILT_BOTH} ycd_filt_t;

  // Fourth byte of a timing code: 1, F, V, H and the protection bits.
  function automatic logic [7:0] code_word(input logic f, input logic v, input logic h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction

endpackage

// ==== logic/ycd_buf_if.sv ====
// Push and unpack port of one sample buffer.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface ycd_buf_if;
  logic        push;
  logic [63:0] wdata;
  logic        full;
  logic        pop;
  logic [7:0]  rbyte;
  logic        empty;
  logic [12:0] level;
  modport store (input push, input wdata, input pop,
                 output full, output rbyte, output empty, output level);
  modport feed  (output push, output wdata, output pop,
                 input full, input rbyte, input empty, input level);
endinterface

// ==== logic/ycd_sync.sv ====
// Two-flop synchroniser with rising edge detect for the incoming video clock.
// Assumes async_in is unrelated to pclk.
`timescale 1ns/10ps
module ycd_sync (
  input  wire logic pclk,     // Block clock.
  input  wire logic presetn,  // Asynchronous reset, active low.
  input  wire logic async_in, // Pin level from another domain.
  output logic      level,    // Synchronised level, three flops deep.
  output logic      rise      // One-cycle pulse on a rising edge.
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ycd_sync_state_t;

  ycd_sync_state_t r;
  ycd_sync_state_t n;

  always_comb begin
    n    = r;
    n.s1 = async_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign level = r.s3;
  assign rise  = r.s2 & ~r.s3;
endmodule

// ==== logic/ycd_fifo.sv ====
// Sample buffer of 64-bit words, unpacked one byte at a time, low byte first.
// Assumes the feeder pushes only while full is low; pops while empty are ignored.
`timescale 1ns/10ps
module ycd_fifo #(
  parameter int WORDS = ycd_pkg::LUMA_WORDS
) (
  input wire logic pclk,    // Block clock.
  input wire logic presetn, // Asynchronous reset, active low.
  ycd_buf_if.store bus      // Push and unpack port.
);
  localparam int AW = $clog2(WORDS);
  localparam int CW = $clog2(WORDS + 1);

  typedef struct packed {
    logic [WORDS-1:0][63:0] mem;
    logic [AW-1:0]          wp;
    logic [AW-1:0]          rp;
    logic [CW-1:0]          cnt;
    logic [2:0]             bidx;
  } ycd_fifo_state_t;

  ycd_fifo_state_t r;
  ycd_fifo_state_t n;

  function automatic logic [AW-1:0] nxt_ptr(input logic [AW-1:0] p);
    return (p == AW'(WORDS - 1)) ? '0 : p + 1'b1;
  endfunction

  logic do_push;
  logic do_pop;
  logic word_done;

  always_comb begin
    n         = r;
    do_push   = bus.push && (r.cnt != CW'(WORDS));
    do_pop    = bus.pop && (r.cnt != '0);
    word_done = do_pop && (r.bidx == 3'h7);
    if (do_push) begin
      n.mem[r.wp] = bus.wdata;
      n.wp        = nxt_ptr(r.wp);
    end
    if (do_pop) begin
      n.bidx = r.bidx + 3'h1;
    end
    if (word_done) begin
      n.rp = nxt_ptr(r.rp);
    end
    if (do_push && !word_done) begin
      n.cnt = r.cnt + 1'b1;
    end else if (!do_push && word_done) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.full  = (r.cnt == CW'(WORDS));
  assign bus.empty = (r.cnt == '0);
  assign bus.rbyte = r.mem[r.rp][{r.bidx, 3'b000} +: 8];
  assign bus.level = 13'({r.cnt, 3'b000}) - 13'(r.bidx);
endmodule

// ==== logic/ycd_top.sv ====
// Display data path for 8-bit BT.656 and 16-bit Y/C output with three sample buffers.
// Assumes an APB master on pclk, a DMA engine filling the buffers and a free video clock in.
//
// Overview of operation
// - Between end and start codes, luma reads 10h and chroma 80h.
// - On lines with V set, active part also carries blanking levels.
// - In Y/C mode, vertical-interval data may replace blanking on V lines.
// - Default-value enable clear gives blanking outside the image window.
// - Buffer splits into 2560-byte luma and two 1280-byte chroma parts.
// - Each buffer has a write-only fill location that reads back nothing.
// - Samples interleave into one stream ordered Cb, Y, Cr, Y.
// - Per-buffer request while enabled, below threshold, and transfer count left.
// - Buffer words are 64 bits, unpacked from low byte upward.
// - Y/C mode puts luma on one lane, alternating Cb/Cr on another.
// - Y/C mode cannot be selected while dual-channel disable is set.
// - In Y/C mode, timing codes appear on both byte lanes.
// - Progressive Y/C uses only field 1; interlaced behaves like BT.656.
// - Y/C mode shares buffers and request generation with BT.656.
// - Output filter only for 8-bit BT.656 or Y/C, bypassed in raw modes.
// - Format x00 selects none, scaling, re-sampling or both by two bits.
// - Formats x01, x10 and x11 never filter, whatever the bits say.
// - Output samples are valid on the rising edge of the output clock.
// - End code starts at hblank begin value, start code at hblank end.
`timescale 1ns/10ps
module ycd_top (
  input  wire logic        pclk,                        // APB and block clock, 100 MHz.
  input  wire logic        presetn,                     // Asynchronous reset, active low.
  input  wire logic [7:0]  paddr,                       // APB byte address.
  input  wire logic        psel,                        // APB select.
  input  wire logic        penable,                     // APB access phase.
  input  wire logic        pwrite,                      // APB direction, high for write.
  input  wire logic [31:0] pwdata,                      // APB write data.
  output logic      [31:0] prdata,                      // APB read data.
  output logic             pready,                      // APB ready.
  output logic             pslverr,                     // APB error.
  input  wire logic        video_clock_in,              // Pixel clock from outside.
  output logic             video_clock_out,             // Pixel clock to the encoder.
  output logic      [19:0] video_data_out,              // Video data, lanes 9:2 and 19:12.
  output logic             luma_transfer_request,       // Luma buffer wants data.
  output logic             blue_chroma_transfer_request, // Cb buffer wants data.
  output logic             red_chroma_transfer_request  // Cr buffer wants data.
);
  typedef struct packed {
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                en;
    logic [2:0]          fmt;
    logic                yc;
    logic                scale;
    logic                chroma_resample_enable;
    logic                dve;
    logic                vbi;
    logic                vflag;
    logic                fflag;
    logic                prog;
    logic                dcd;
    logic [12:0]         thr;
    logic [15:0]         xfer_cnt;
    logic [11:0]         hbegin;
    logic [11:0]         hend;
    logic [11:0]         win_start;
    logic [11:0]         win_stop;
    logic [11:0]         line_last;
    logic [7:0]          def_y;
    logic [7:0]          def_c;
    logic [31:0]         lo;
    logic [11:0]         pcount;
    ycd_pkg::ycd_sect_t  sect;
    logic [1:0]          cidx;
    logic [1:0]          phase;
    logic [19:0]         vout;
    logic                vclk_out;
    logic                req_y;
    logic                req_cb;
    logic                req_cr;
  } ycd_state_t;

  ycd_state_t r;
  ycd_state_t n;

  ycd_buf_if ybus ();
  ycd_buf_if cbbus ();
  ycd_buf_if crbus ();

  logic vclk_level;
  logic vclk_rise;

  ycd_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (video_clock_in),
    .level    (vclk_level),
    .rise     (vclk_rise)
  );

  ycd_fifo #(.WORDS(ycd_pkg::LUMA_WORDS)) u_luma (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (ybus)
  );

  ycd_fifo #(.WORDS(ycd_pkg::CHROMA_WORDS)) u_blue (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (cbbus)
  );

  ycd_fifo #(.WORDS(ycd_pkg::CHROMA_WORDS)) u_red (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (crbus)
  );

  function automatic ycd_pkg::ycd_filt_t filt_mode(input logic [2:0] fmt,
                                                  input logic chroma_resample_enable, input logic scale);
    if (fmt[1:0] != 2'b00) begin
      return ycd_pkg::FILT_NONE;
    end
    return ycd_pkg::ycd_filt_t'({chroma_resample_enable, scale});
  endfunction

  logic       setup;
  logic       access;
  logic       wr;
  logic       pop_y;
  logic       pop_cb;
  logic       pop_cr;
  logic       csel;
  logic       in_win;
  logic       show;
  logic [7:0] y_b;
  logic [7:0] c_b;

  assign setup  = psel && !penable;
  assign access = psel && penable && r.pready;
  assign wr     = access && pwrite;

  // Fill locations: the low word is held, the high word completes and pushes the word.
  assign ybus.push   = wr && (paddr == ycd_pkg::ADDR_Y_HI) && !ybus.full;
  assign cbbus.push  = wr && (paddr == ycd_pkg::ADDR_CB_HI) && !cbbus.full;
  assign crbus.push  = wr && (paddr == ycd_pkg::ADDR_CR_HI) && !crbus.full;
  assign ybus.wdata  = {pwdata, r.lo};
  assign cbbus.wdata = {pwdata, r.lo};
  assign crbus.wdata = {pwdata, r.lo};
  assign ybus.pop    = pop_y;
  assign cbbus.pop   = pop_cb;
  assign crbus.pop   = pop_cr;

  always_comb begin
    n         = r;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    pop_y     = 1'b0;
    pop_cb    = 1'b0;
    pop_cr    = 1'b0;
    y_b       = ycd_pkg::BLANK_Y;
    c_b       = ycd_pkg::BLANK_C;
    csel      = r.yc ? r.phase[0] : r.phase[1];
    in_win    = (r.pcount >= r.win_start) && (r.pcount < r.win_stop);
    show      = !r.vflag || (r.yc && r.vbi);

    // Read data and error are prepared in the setup cycle so the access phase sees flops.
    if (setup) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr)
        ycd_pkg::ADDR_CTRL: n.prdata = 32'({r.prog, r.fflag, r.vflag, r.vbi, r.dve, r.chroma_resample_enable,
                                           r.scale, r.yc, r.fmt, r.en});
        ycd_pkg::ADDR_PORT: n.prdata = 32'(r.dcd);
        ycd_pkg::ADDR_THR:  n.prdata = 32'(r.thr);
        ycd_pkg::ADDR_CNT:  n.prdata = 32'(r.xfer_cnt);
        ycd_pkg::ADDR_HBL:  n.prdata = {4'h0, r.hend, 4'h0, r.hbegin};
        ycd_pkg::ADDR_WIN:  n.prdata = {4'h0, r.win_stop, 4'h0, r.win_start};
        ycd_pkg::ADDR_LINE: n.prdata = 32'(r.line_last);
        ycd_pkg::ADDR_DEF:  n.prdata = 32'({r.def_c, r.def_y});
        ycd_pkg::ADDR_STAT: n.prdata = {15'h0000, r.req_cr, r.req_cb, r.req_y,
                                        filt_mode(r.fmt, r.chroma_resample_enable, r.scale), r.pcount};
        ycd_pkg::ADDR_Y_LO, ycd_pkg::ADDR_CB_LO, ycd_pkg::ADDR_CR_LO: ;
        ycd_pkg::ADDR_Y_HI:  n.pslverr = pwrite && ybus.full;
        ycd_pkg::ADDR_CB_HI: n.pslverr = pwrite && cbbus.full;
        ycd_pkg::ADDR_CR_HI: n.pslverr = pwrite && crbus.full;
        default:             n.pslverr = 1'b1;
      endcase
    end

    // Requests share one gate in both formats; chroma bytes stand for two pixels each.
    n.req_y  = r.en && (r.xfer_cnt != 16'h0000) && (14'(ybus.level) < 14'(r.thr));
    n.req_cb = r.en && (r.xfer_cnt != 16'h0000)
               && ({cbbus.level, 1'b0} < 14'(r.thr));
    n.req_cr = r.en && (r.xfer_cnt != 16'h0000)
               && ({crbus.level, 1'b0} < 14'(r.thr));
    if (n.req_y && !r.req_y && (r.xfer_cnt != 16'h0000)) begin
      n.xfer_cnt = r.xfer_cnt - 16'h0001;
    end

    if (wr) begin
      case (paddr)
        ycd_pkg::ADDR_CTRL: begin
          n.en     = pwdata[ycd_pkg::CTRL_EN];
          n.fmt    = pwdata[ycd_pkg::CTRL_FMT +: 3];
          n.yc     = pwdata[ycd_pkg::CTRL_YC];
          n.scale  = pwdata[ycd_pkg::CTRL_SCALE];
          n.chroma_resample_enable = pwdata[ycd_pkg::CTRL_CHROMA_RESAMPLE_ENABLE];
          n.dve    = pwdata[ycd_pkg::CTRL_DVE];
          n.vbi    = pwdata[ycd_pkg::CTRL_VBI];
          n.vflag  = pwdata[ycd_pkg::CTRL_VFLAG];
          n.fflag  = pwdata[ycd_pkg::CTRL_FFLAG];
          n.prog   = pwdata[ycd_pkg::CTRL_PROG];
        end
        ycd_pkg::ADDR_PORT: n.dcd = pwdata[0];
        ycd_pkg::ADDR_THR:  n.thr = pwdata[12:0];
        ycd_pkg::ADDR_CNT:  n.xfer_cnt = pwdata[15:0];
        ycd_pkg::ADDR_HBL: begin
          n.hbegin = pwdata[11:0];
          n.hend   = pwdata[ycd_pkg::HI_LSB +: 12];
        end
        ycd_pkg::ADDR_WIN: begin
          n.win_start = pwdata[11:0];
          n.win_stop  = pwdata[ycd_pkg::HI_LSB +: 12];
        end
        ycd_pkg::ADDR_LINE: n.line_last = pwdata[11:0];
        ycd_pkg::ADDR_DEF: begin
          n.def_y = pwdata[7:0];
          n.def_c = pwdata[15:8];
        end
        ycd_pkg::ADDR_Y_LO, ycd_pkg::ADDR_CB_LO, ycd_pkg::ADDR_CR_LO: n.lo = pwdata;
        default: ;
      endcase
    end
    if (n.dcd) begin
      n.yc = 1'b0;
    end

    if (vclk_rise) begin
      n.pcount = (r.pcount == r.line_last) ? 12'h000 : r.pcount + 12'h001;
      if ((r.pcount == r.hbegin) || (r.pcount == r.hend)) begin
        n.sect = (r.pcount == r.hbegin) ? ycd_pkg::SECT_EAV : ycd_pkg::SECT_SAV;
        n.cidx = 2'h1;
        y_b    = ycd_pkg::CODE_PRE;
        c_b    = ycd_pkg::CODE_PRE;
      end else begin
        unique case (r.sect)
          ycd_pkg::SECT_EAV, ycd_pkg::SECT_SAV: begin
            y_b    = (r.cidx == 2'h3)
                     ? ycd_pkg::code_word(r.fflag && !(r.yc && r.prog), r.vflag,
                                          r.sect == ycd_pkg::SECT_EAV)
                     : 8'h00;
            c_b    = y_b;
            n.cidx = r.cidx + 2'h1;
            if (r.cidx == 2'h3) begin
              n.sect  = (r.sect == ycd_pkg::SECT_EAV) ? ycd_pkg::SECT_HBL : ycd_pkg::SECT_ACT;
              n.phase = 2'h0;
            end
          end
          ycd_pkg::SECT_HBL: begin
            n.phase = r.phase + 2'h1;
          end
          ycd_pkg::SECT_ACT: begin
            n.phase = r.phase + 2'h1;
            if (show && in_win) begin
              y_b    = ybus.rbyte;
              c_b    = csel ? crbus.rbyte : cbbus.rbyte;
              pop_y  = r.yc || r.phase[0];
              pop_cb = (r.yc || !r.phase[0]) && !csel;
              pop_cr = (r.yc || !r.phase[0]) && csel;
            end else if (show && r.dve) begin
              y_b = r.def_y;
              c_b = r.def_c;
            end
            // Otherwise the blanking levels stay in place.
          end
        endcase
      end
      if (r.yc) begin
        n.vout = {c_b, 2'b00, y_b, 2'b00};
      end else begin
        n.vout = {10'h000, r.phase[0] ? y_b : c_b, 2'b00};
      end
    end
    // Output clock rises one cycle after the data has settled.
    n.vclk_out = vclk_level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r           <= '0;
      r.thr       <= ycd_pkg::RST_THR;
      r.hbegin    <= ycd_pkg::RST_HBEGIN;
      r.hend      <= ycd_pkg::RST_HEND;
      r.win_start <= ycd_pkg::RST_WIN_START;
      r.win_stop  <= ycd_pkg::RST_WIN_STOP;
      r.line_last <= ycd_pkg::RST_LINE_LAST;
      r.sect      <= ycd_pkg::SECT_HBL;
    end else begin
      r <= n;
    end
  end

  assign prdata                       = r.prdata;
  assign pready                       = r.pready;
  assign pslverr                      = r.pslverr;
  assign video_clock_out              = r.vclk_out;
  assign video_data_out               = r.vout;
  assign luma_transfer_request        = r.req_y;
  assign blue_chroma_transfer_request = r.req_cb;
  assign red_chroma_transfer_request  = r.req_cr;

  default clocking cb_main @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic code_hit;
  assign code_hit = (r.pcount == r.hbegin) || (r.pcount == r.hend);

  property p_hblank_levels;
    vclk_rise && !code_hit && (r.sect == ycd_pkg::SECT_HBL) |=>
      (r.vout[9:2] == ycd_pkg::BLANK_Y) || (r.vout[9:2] == ycd_pkg::BLANK_C);
  endproperty
  a_hblank_levels: assert property (p_hblank_levels)
    else $error("Non-blank byte during horizontal blanking.");

  property p_vblank_levels;
    vclk_rise && !code_hit && (r.sect == ycd_pkg::SECT_ACT) && r.vflag && !r.vbi |=>
      (r.vout[9:2] == ycd_pkg::BLANK_Y) || (r.vout[9:2] == ycd_pkg::BLANK_C);
  endproperty
  a_vblank_levels: assert property (p_vblank_levels)
    else $error("Non-blank byte on a vertical blanking line.");

  property p_bt_order;
    vclk_rise && !code_hit && !r.yc && (r.sect == ycd_pkg::SECT_HBL) |=>
      r.vout[9:2] == ($past(r.phase[0]) ? ycd_pkg::BLANK_Y : ycd_pkg::BLANK_C);
  endproperty
  a_bt_order: assert property (p_bt_order)
    else $error("Luma and chroma slots out of order.");

  property p_req_gate;
    !r.en || (r.xfer_cnt == 16'h0000) |=> !r.req_y && !r.req_cb && !r.req_cr;
  endproperty
  a_req_gate: assert property (p_req_gate)
    else $error("Transfer request raised while gated off.");

  property p_dcd_blocks_yc;
    r.dcd |-> !r.yc;
  endproperty
  a_dcd_blocks_yc: assert property (p_dcd_blocks_yc)
    else $error("Y/C mode active with dual channel disabled.");

  property p_yc_codes;
    r.yc && vclk_rise && code_hit |=> (r.vout[9:2] == 8'hFF) && (r.vout[19:12] == 8'hFF);
  endproperty
  a_yc_codes: assert property (p_yc_codes)
    else $error("Timing code missing from a Y/C lane.");

  property p_eav_start;
    vclk_rise && (r.pcount == r.hbegin) |=>
      (r.sect == ycd_pkg::SECT_EAV) && (r.vout[9:2] == ycd_pkg::CODE_PRE);
  endproperty
  a_eav_start: assert property (p_eav_start)
    else $error("End code not started at hblank begin.");

  property p_filter_off;
    setup && (paddr == ycd_pkg::ADDR_STAT) && (r.fmt[1:0] != 2'b00) |=> r.prdata[13:12] == 2'b00;
  endproperty
  a_filter_off: assert property (p_filter_off)
    else $error("Filter active in a non-8-bit format.");

  property p_filter_sel;
    setup && (paddr == ycd_pkg::ADDR_STAT) && (r.fmt[1:0] == 2'b00) |=>
      r.prdata[13:12] == {$past(r.chroma_resample_enable), $past(r.scale)};
  endproperty
  a_filter_sel: assert property (p_filter_sel)
    else $error("Filter mode does not follow its bits.");

  property p_fill_reads_zero;
    setup && !pwrite && (paddr == ycd_pkg::ADDR_Y_LO) |=> r.prdata == 32'h0000_0000;
  endproperty
  a_fill_reads_zero: assert property (p_fill_reads_zero)
    else $error("Fill location returned data.");
endmodule

// ==== bench/ycd_enc_model.sv ====
// Encoder-side model: free pixel clock to the block, samples captured per output clock.
// Assumes video_clock_out follows video_clock_in and pclk is much faster than both.
`timescale 1ns/10ps
module ycd_enc_model (
  input  wire logic        pclk,            // Block clock, used to find output clock edges.
  input  wire logic        video_clock_out, // Output clock from the block.
  input  wire logic [19:0] video_data_out,  // Video data from the block.
  output logic             video_clock_in   // Free-running pixel clock, 125 ns period.
);
  logic [19:0] q[$];
  logic        last_r = 1'b0;

  // A video clock runs free, so it is not stopped between lines.
  initial begin
    video_clock_in = 1'b0;
    #3.3;
    forever #62.5 video_clock_in = ~video_clock_in;
  end

  always @(posedge pclk) begin
    last_r <= video_clock_out;
    if (video_clock_out && !last_r) q.push_back(video_data_out);
  end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench: APB register checks and capture of the video stream.
// Assumes ycd_pkg and the design files are compiled before it.
`timescale 1ns/10ps
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, vci, vco, yreq, breq, rreq;
  logic [19:0] vdo;
  logic [63:0] w[3];
  logic [12:0] thr;
  logic [7:0]  mq[$];
  int          miscompares = 0;
  int          comparisons = 0;
  int          cyc = 0;

  ycd_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .video_clock_in(vci), .video_clock_out(vco),
    .video_data_out(vdo), .luma_transfer_request(yreq),
    .blue_chroma_transfer_request(breq), .red_chroma_transfer_request(rreq));
  ycd_enc_model enc_u (.pclk(pclk), .video_clock_out(vco), .video_data_out(vdo),
    .video_clock_in(vci));

  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request holds until ready is sampled high at a rising edge; data is taken there.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Finds code preambles, then checks the code and the four samples after it.
  task automatic video(input logic [31:0] ctrl, input logic yc, input logic v);
    logic [19:0] s[$];
    logic [7:0]  b, c, l;
    logic        h;
    int          codes;
    codes = 0;
    apb(1'b1, ycd_pkg::ADDR_CTRL, ctrl);
    // Samples still in flight from the old mode are let through before capture starts.
    repeat (4) @(posedge pclk);
    enc_u.q.delete();
    repeat (2600) @(posedge pclk);
    s = enc_u.q;
    for (int i = 0; i + 8 < s.size(); i++) begin
      if ({s[i][9:2], s[i+1][9:2], s[i+2][9:2]} == 24'hFF_0000) begin
        codes++;
        h = s[i+3][6];
        b = h ? (v ? 8'hB6 : 8'h9D) : (v ? 8'hAB : 8'h80);
        for (int k = 0; k < 8; k++) begin
          c = (k == 0) ? 8'hFF : (k < 3) ? 8'h00 : (k == 3) ? b : 8'h80;
          l = (k > 3 && (yc || k[0])) ? 8'h10 : c;
          if (k < 4 || v || h)
            chk(32'(s[i+k]), 32'(yc ? {c, 2'b0, l, 2'b0} : {10'h0, l, 2'b0}));
          else if (mq.size() > 0)
            chk(32'(s[i+k]), {22'h0, mq.pop_front(), 2'b0});
        end
        if (!v && !h) chk(32'(s[i+8]), 32'h0000_0200);
      end
    end
    chk(32'(codes > 4), 32'h0000_0001);
  endtask

  initial begin
    void'($urandom(32'hbb77c055));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ycd_pkg::ADDR_THR, '0);
    chk(rd, 32'h0000_0100);
    apb(1'b0, ycd_pkg::ADDR_HBL, '0);
    chk(rd, 32'h0354_02D0);
    apb(1'b0, 8'h3C, '0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, ycd_pkg::ADDR_CB_LO, '0);
    chk({err, rd[30:0]}, 32'h0000_0000);
    apb(1'b0, ycd_pkg::ADDR_Y_LO, '0);
    chk({err, rd[30:0]}, 32'h0000_0000);
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, ycd_pkg::ADDR_CTRL, {25'h0, i[4:3], 1'b0, i[2:0], 1'b0});
      apb(1'b0, ycd_pkg::ADDR_STAT, '0);
      chk(32'(rd[13:12]), (i[1:0] == 2'b00) ? 32'(i[4:3]) : 32'h0);
    end
    apb(1'b1, ycd_pkg::ADDR_PORT, 32'h0000_0001);
    apb(1'b1, ycd_pkg::ADDR_CTRL, 32'h0000_0010);
    apb(1'b0, ycd_pkg::ADDR_CTRL, '0);
    chk(32'(rd[4]), 32'h0000_0000);
    apb(1'b1, ycd_pkg::ADDR_PORT, 32'h0000_0000);
    apb(1'b1, ycd_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (3) @(negedge pclk);
    chk(32'({yreq, breq, rreq}), 32'h0000_0000);
    thr = 13'($urandom_range(8191, 1));
    apb(1'b1, ycd_pkg::ADDR_THR, 32'(thr));
    apb(1'b1, ycd_pkg::ADDR_CNT, 32'h0000_0003);
    repeat (3) @(negedge pclk);
    chk(32'({yreq, breq, rreq}), 32'h0000_0007);
    apb(1'b1, ycd_pkg::ADDR_HBL, 32'h0030_0020);
    apb(1'b1, ycd_pkg::ADDR_LINE, 32'h0000_003F);
    video(32'h0000_0201, 1'b0, 1'b1);
    video(32'h0000_0211, 1'b1, 1'b1);
    apb(1'b1, ycd_pkg::ADDR_CTRL, 32'h0000_0201);
    for (int j = 0; j < 3; j++) begin
      w[j] = {$urandom, $urandom};
      apb(1'b1, 8'(ycd_pkg::ADDR_Y_LO + 8 * j), w[j][31:0]);
      apb(1'b1, 8'(ycd_pkg::ADDR_Y_LO + 8 * j + 4), w[j][63:32]);
    end
    apb(1'b1, ycd_pkg::ADDR_Y_LO, $urandom);
    apb(1'b1, ycd_pkg::ADDR_Y_HI, $urandom);
    for (int j = 0; j < 2; j++)
      mq = {mq, w[1][8*j +: 8], w[0][16*j +: 8], w[2][8*j +: 8], w[0][16*j+8 +: 8]};
    apb(1'b1, ycd_pkg::ADDR_WIN, 32'h0038_0034);
    do apb(1'b0, ycd_pkg::ADDR_STAT, '0);
    while (rd[11:0] < 12'h020 || rd[11:0] > 12'h028);
    video(32'h0000_0001, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule
